// file: pkg/upv_pkg.sv
// Constants and types shared by the host and panel ends of the video input link.
// Assumes both ends run on one reference clock and meet through upv_link_if.
// Summary of operation
// - Host sends 480 active, 50-120 blank clocks.
// - Host sends 2160 active, 40-600 blank lines.
// - Host pixel clock 60-78 MHz, frame 47-63 Hz.
// - Panel uses data enable only, ignores syncs.
// - Host adds blank margin when spreading clock; the host here has no spread-clock mode and a fixed H_BLANK.
// - Strap low: black screen without signal.
// - Strap high: test pattern without signal.
// - Lane skew up to 5 UI, deskewed; the panel here takes one word per clock with no deskew stage.
// - Sub-block skew up to one DE period, realigned; the panel here has no realignment stage.
// - 10-bit packing: MSBs low bytes, LSBs byte3.
// - 8-bit packing: RGB bytes, byte3 unused.
// - Colour codes unsigned, larger is brighter.
// - Supply off at least 1.0 s.
// - No signals before module supply on.
// - Data lines held low while supply off.
// - Lock and hot-plug flags may rise early.
// - Depth strap high selects 10-bit, low 8-bit.
package upv_pkg;

  localparam int unsigned H_ACTIVE      = 480;
  localparam int unsigned H_BLANK_MIN   = 50;
  localparam int unsigned H_BLANK_TYP   = 70;
  localparam int unsigned H_BLANK_MAX   = 120;
  localparam int unsigned V_ACTIVE      = 2160;
  localparam int unsigned V_BLANK_MIN   = 40;
  localparam int unsigned V_BLANK_TYP   = 90;
  localparam int unsigned V_BLANK_MAX   = 600;
  localparam int unsigned LANE_SKEW_UI  = 5;
  localparam int unsigned SUB_SKEW_DE   = 1;
  localparam int unsigned NOSIG_LINES   = 4;
  localparam int unsigned WORD_W        = 32;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned HCNT_W        = 10;
  localparam int unsigned VCNT_W        = 12;
  localparam int unsigned B10_R_HI      = 0;
  localparam int unsigned B10_G_HI      = 8;
  localparam int unsigned B10_B_HI      = 16;
  localparam int unsigned B10_B_LO      = 26;
  localparam int unsigned B10_G_LO      = 28;
  localparam int unsigned B10_R_LO      = 30;
  localparam logic [7:0]  PAT_STEP      = 8'h04;

  typedef struct packed {
    logic [9:0] r;
    logic [9:0] g;
    logic [9:0] b;
  } upv_rgb_s;

  function automatic logic [WORD_W-1:0] upv_pack(input upv_rgb_s px, input logic ten_bit);
    logic [WORD_W-1:0] w;
    w = '0;
    if (ten_bit) begin
      w[B10_R_HI +: 8] = px.r[9:2];
      w[B10_G_HI +: 8] = px.g[9:2];
      w[B10_B_HI +: 8] = px.b[9:2];
      w[B10_B_LO +: 2] = px.b[1:0];
      w[B10_G_LO +: 2] = px.g[1:0];
      w[B10_R_LO +: 2] = px.r[1:0];
    end else begin
      w[B10_R_HI +: 8] = px.r[7:0];
      w[B10_G_HI +: 8] = px.g[7:0];
      w[B10_B_HI +: 8] = px.b[7:0];
    end
    return w;
  endfunction : upv_pack

  function automatic upv_rgb_s upv_unpack(input logic [WORD_W-1:0] w, input logic ten_bit);
    upv_rgb_s px;
    if (ten_bit) begin
      px.r = {w[B10_R_HI +: 8], w[B10_R_LO +: 2]};
      px.g = {w[B10_G_HI +: 8], w[B10_G_LO +: 2]};
      px.b = {w[B10_B_HI +: 8], w[B10_B_LO +: 2]};
    end else begin
      // 8-bit codes scaled to the 10-bit range, keeping order
      px.r = {w[B10_R_HI +: 8], 2'h0};
      px.g = {w[B10_G_HI +: 8], 2'h0};
      px.b = {w[B10_B_HI +: 8], 2'h0};
    end
    return px;
  endfunction : upv_unpack

endpackage : upv_pkg

// file: pkg/upv_link_if.sv
// Link between the host transmitter and the panel receiver.
// Assumes one shared clock; pins carry data enable, syncs, word and status flags.
`timescale 1ns/100ps
interface upv_link_if;
  import upv_pkg::*;
  logic              de;
  logic              hsync;
  logic              vsync;
  logic [WORD_W-1:0] data;
  logic              link_lock_flag;
  logic              hot_plug_flag;

  modport host (output de, output hsync, output vsync, output data,
                input link_lock_flag, input hot_plug_flag);
  modport panel (input de, input hsync, input vsync, input data,
                 output link_lock_flag, output hot_plug_flag);
endinterface : upv_link_if

// file: src/upv_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/100ps
module upv_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             rdy_r;
  logic             push;
  logic             pop;

  // Ready is registered from the next count so the source sees a flop
  assign in_ready_o  = rdy_r;
  assign cnt_nxt     = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem[rd_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_r] <= in_data_i;
    end
    if (!rst_b_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b1;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      rdy_r <= (cnt_nxt != (AW+1)'(DEPTH));
    end
  end
endmodule : upv_fifo

// file: src/upv_host.sv
// Host transmitter: frames pixels from a user stream into DE timing with hsync/vsync pulses and packs lane words.
// Assumes the pixel stream arrives on ref_clk_i; a 16-word FIFO absorbs it and stalls the source.
`timescale 1ns/100ps
module upv_host
  import upv_pkg::*;
#(
  parameter int unsigned H_BLANK = H_BLANK_TYP,
  parameter int unsigned V_BLANK = V_BLANK_TYP
) (
  input  wire logic     ref_clk_i,
  input  wire logic     rst_b_i,
  input  wire logic     supply_on_i,
  input  wire logic     ten_bit_i,
  input  upv_rgb_s      px_data_i,
  input  wire logic     px_valid_i,
  output logic          px_ready_o,
  output logic          lock_seen_o,
  upv_link_if.host      link
);
  typedef enum logic [1:0] {HS_IDLE, HS_ACTIVE, HS_HBLANK} upv_hstate_e;
  typedef struct packed {
    upv_hstate_e       st;
    logic [HCNT_W-1:0] h;
    logic [VCNT_W-1:0] v;
    logic              de;
    logic              hs;
    logic              vs;
    logic [WORD_W-1:0] data;
    logic              lock;
  } upv_host_s;

  upv_host_s  s_r;
  upv_host_s  s_nxt;
  upv_rgb_s   f_px;
  logic       f_valid;
  logic       f_pop;
  logic       lock_m_r;
  logic       lock_s_r;

  upv_fifo #(.WIDTH($bits(upv_rgb_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   (px_data_i),
    .in_valid_i  (px_valid_i),
    .in_ready_o  (px_ready_o),
    .out_data_o  (f_px),
    .out_valid_o (f_valid),
    .out_ready_i (f_pop)
  );

  // One word popped per active clock; a word starved mid-line goes out as zero
  assign f_pop = (s_r.st == HS_ACTIVE) & f_valid;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.de   = 1'b0;
    s_nxt.hs   = 1'b0;
    s_nxt.vs   = 1'b0;
    s_nxt.data = '0;
    case (s_r.st)
      HS_IDLE: begin
        s_nxt.h = '0;
        s_nxt.v = '0;
        if (supply_on_i && f_valid) begin
          s_nxt.st = HS_ACTIVE;
        end
      end
      HS_ACTIVE: begin
        s_nxt.de   = 1'b1;
        s_nxt.data = f_valid ? upv_pack(f_px, ten_bit_i) : '0;
        if (s_r.h == HCNT_W'(H_ACTIVE - 1)) begin
          s_nxt.h  = '0;
          s_nxt.st = HS_HBLANK;
        end else begin
          s_nxt.h = s_r.h + 1'b1;
        end
      end
      HS_HBLANK: begin
        s_nxt.hs = (s_r.h == '0);
        s_nxt.vs = (s_r.v >= VCNT_W'(V_ACTIVE)) && (s_r.h == '0);
        if (s_r.v < VCNT_W'(V_ACTIVE) && s_r.h == HCNT_W'(H_BLANK - 1)) begin
          s_nxt.h = '0;
          s_nxt.v = s_r.v + 1'b1;
          s_nxt.st = (s_r.v == VCNT_W'(V_ACTIVE - 1)) ? HS_HBLANK : HS_ACTIVE;
        end else if (s_r.h == HCNT_W'(H_ACTIVE + H_BLANK - 1)) begin
          // Blank lines run a whole line total each
          s_nxt.h = '0;
          if (s_r.v == VCNT_W'(V_ACTIVE + V_BLANK - 1)) begin
            s_nxt.v  = '0;
            s_nxt.st = HS_ACTIVE;
          end else begin
            s_nxt.v = s_r.v + 1'b1;
          end
        end else begin
          s_nxt.h = s_r.h + 1'b1;
        end
      end
      default: s_nxt.st = HS_IDLE;
    endcase
    if (!supply_on_i) begin
      s_nxt.st   = HS_IDLE;
      s_nxt.de   = 1'b0;
      s_nxt.data = '0;
    end
    s_nxt.lock = lock_s_r;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      s_r      <= '0;
      lock_m_r <= 1'b0;
      lock_s_r <= 1'b0;
    end else begin
      s_r      <= s_nxt;
      lock_m_r <= link.link_lock_flag;
      lock_s_r <= lock_m_r;
    end
  end

  assign link.de     = s_r.de;
  assign link.hsync  = s_r.hs;
  assign link.vsync  = s_r.vs;
  assign link.data   = s_r.data;
  assign lock_seen_o = s_r.lock;
endmodule : upv_host

// file: src/upv_panel.sv
// Panel receiver: finds active video from data enable, unpacks pixels and substitutes black or a test pattern.
// Assumes link pins come from another device and are synchronised here; straps are static pins.
`timescale 1ns/100ps
module upv_panel
  import upv_pkg::*;
#(
  parameter int unsigned NOSIG_TIMEOUT = (H_ACTIVE + H_BLANK_MAX) * NOSIG_LINES
) (
  input  wire logic     ref_clk_i,
  input  wire logic     rst_b_i,
  input  wire logic     depth_strap_i,
  input  wire logic     auto_test_pattern_i,
  upv_link_if.panel     link,
  output upv_rgb_s      px_o,
  output logic          px_valid_o,
  output logic [HCNT_W-1:0] px_col_o,
  output logic [VCNT_W-1:0] px_row_o,
  output logic          signal_ok_o
);
  localparam int unsigned TO_W = $clog2(NOSIG_TIMEOUT + 1);

  typedef struct packed {
    logic              de_m;
    logic              de_s;
    logic [WORD_W-1:0] d_m;
    logic [WORD_W-1:0] d_s;
    logic              bs_m;
    logic              bs_s;
    logic              ps_m;
    logic              ps_s;
    logic              de_d;
    logic [HCNT_W-1:0] col;
    logic [VCNT_W-1:0] row;
    logic [TO_W-1:0]   idle;
    logic              ok;
    logic              lock;
    logic              hpd;
    upv_rgb_s          px;
    logic              pv;
    logic [HCNT_W-1:0] ocol;
    logic [VCNT_W-1:0] orow;
    logic [7:0]        frame;
  } upv_panel_s;

  upv_panel_s s_r;
  upv_panel_s s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.de_m = link.de;
    s_nxt.de_s = s_r.de_m;
    s_nxt.d_m  = link.data;
    s_nxt.d_s  = s_r.d_m;
    s_nxt.bs_m = depth_strap_i;
    s_nxt.bs_s = s_r.bs_m;
    s_nxt.ps_m = auto_test_pattern_i;
    s_nxt.ps_s = s_r.ps_m;
    s_nxt.de_d = s_r.de_s;
    s_nxt.hpd  = 1'b1;
    // Column and row counted from DE alone while signal is ok, column free-runs without signal; sync pins are never read
    if (s_r.de_s) begin
      s_nxt.col = s_r.col + 1'b1;
    end else begin
      s_nxt.col = '0;
    end
    if (s_r.de_d && !s_r.de_s) begin
      s_nxt.row = s_r.row + 1'b1;
    end
    // A DE gap longer than any line blank marks vertical blank; next line is row 0
    if (s_r.de_s) begin
      s_nxt.idle = '0;
    end else if (s_r.idle != TO_W'(NOSIG_TIMEOUT)) begin
      s_nxt.idle = s_r.idle + 1'b1;
    end
    if (s_r.idle > TO_W'(H_BLANK_MAX) && !s_r.de_s) begin
      s_nxt.row = '0;
    end
    s_nxt.ok   = (s_r.idle != TO_W'(NOSIG_TIMEOUT));
    s_nxt.lock = s_r.ok;
    if (s_r.idle == TO_W'(H_BLANK_MAX + 1)) begin
      s_nxt.frame = s_r.frame + 1'b1;
    end
    s_nxt.ocol = s_r.col;
    s_nxt.orow = s_r.row;
    if (s_r.ok) begin
      s_nxt.pv = s_r.de_s;
      s_nxt.px = upv_unpack(s_r.d_s, s_r.bs_s);
    end else if (s_r.ps_s) begin
      s_nxt.pv   = 1'b1;
      s_nxt.px.r = {s_r.col[7:0] + s_r.frame, 2'h0};
      s_nxt.px.g = {s_r.col[7:0] ^ PAT_STEP, 2'h0};
      s_nxt.px.b = {s_r.frame, 2'h0};
      s_nxt.col  = s_r.col + 1'b1;
    end else begin
      s_nxt.pv = 1'b1;
      s_nxt.px = '0;
      s_nxt.col = s_r.col + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.link_lock_flag = s_r.lock;
  assign link.hot_plug_flag  = s_r.hpd;
  assign px_o                = s_r.px;
  assign px_valid_o          = s_r.pv;
  assign px_col_o            = s_r.ocol;
  assign px_row_o            = s_r.orow;
  assign signal_ok_o         = s_r.ok;
endmodule : upv_panel

// file: testbench/upv_link_checker.sv
// Assertions on the link between the host and panel ends.
// Assumes it is wired to the interface signals, clocked by the shared reference clock.
`timescale 1ns/100ps
module upv_link_checker
  import upv_pkg::*;
#(
  parameter int unsigned H_BLANK       = H_BLANK_TYP,
  parameter int unsigned NOSIG_TIMEOUT = (H_ACTIVE + H_BLANK_MAX) * NOSIG_LINES
) (
  input wire logic              ref_clk_i,
  input wire logic              rst_b_i,
  input wire logic              de,
  input wire logic              hsync,
  input wire logic              vsync,
  input wire logic [WORD_W-1:0] data,
  input wire logic              link_lock_flag,
  input wire logic              hot_plug_flag
);
  logic [15:0] hi_cnt_r;
  logic [15:0] lo_cnt_r;
  logic        seen_fall_r;

  // Run lengths of data enable high and low
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      hi_cnt_r    <= 16'h0000;
      lo_cnt_r    <= 16'h0000;
      seen_fall_r <= 1'b0;
    end else begin
      hi_cnt_r    <= de ? hi_cnt_r + 16'h0001 : 16'h0000;
      lo_cnt_r    <= de ? 16'h0000 : lo_cnt_r + 16'h0001;
      seen_fall_r <= seen_fall_r | (!de && hi_cnt_r != 16'h0000);
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_line_start;
    !de ##1 de;
  endsequence
  sequence s_line_body;
    de [*8];
  endsequence

  property p_line_start;
    s_line_start |=> s_line_body;
  endproperty
  property p_line_len;
    $fell(de) |-> hi_cnt_r == 16'(H_ACTIVE);
  endproperty
  property p_blank_len;
    $rose(de) && seen_fall_r |-> lo_cnt_r == 16'(H_BLANK);
  endproperty
  property p_hs_pulse;
    hsync |=> !hsync;
  endproperty
  property p_vs_pulse;
    vsync |=> !vsync;
  endproperty
  property p_hpd_up;
    $past(rst_b_i) |-> hot_plug_flag;
  endproperty
  property p_lock_drop;
    lo_cnt_r == 16'(NOSIG_TIMEOUT + 8) |-> !link_lock_flag;
  endproperty
  property p_lock_rise;
    $rose(link_lock_flag) |-> lo_cnt_r < 16'(NOSIG_TIMEOUT);
  endproperty

  a_line_start: assert property (p_line_start) else $error("line shorter than 9 clocks");
  a_line_len: assert property (p_line_len) else $error("active line length wrong");
  a_blank_len: assert property (p_blank_len) else $error("horizontal blank length wrong");
  a_hs_pulse: assert property (p_hs_pulse) else $error("hsync not a single pulse");
  a_vs_pulse: assert property (p_vs_pulse) else $error("vsync not a single pulse");
  a_hpd_up: assert property (p_hpd_up) else $error("hot plug flag low after reset");
  a_lock_drop: assert property (p_lock_drop) else $error("lock kept without video");
  a_lock_rise: assert property (p_lock_rise) else $error("lock rose without video");
endmodule : upv_link_checker

// file: testbench/testbench.sv
// Bench joining host and panel ends through the link interface.
// Assumes package, interface and both ends; 50 MHz clock, reset held 16 cycles.
`timescale 1ns/100ps
module testbench;
  import upv_pkg::*;
  localparam int unsigned HB  = H_BLANK_MIN;
  localparam int unsigned NST = 200;
  logic              ref_clk_i = 1'b0;
  logic              rst_b_i   = 1'b0;
  logic              supply_on = 1'b0;
  logic              ten_bit   = 1'b1;
  logic              strap     = 1'b1;
  logic              auto_test_pattern = 1'b0;
  logic              px_valid  = 1'b0;
  upv_rgb_s          px_data   = '1;
  logic              px_ready, lock_seen, px_vld, sig_ok, seen;
  upv_rgb_s          px_out, e;
  logic [HCNT_W-1:0] col;
  logic [VCNT_W-1:0] row;
  upv_rgb_s          q[$];
  upv_rgb_s          pipe[4];
  int                cp[4];
  int                rp[4];
  logic [3:0]        pv = 4'h0;
  int                xcol = 0;
  int                xrow = 0;
  int                gap = 0;
  int                err_count = 0;
  int                checks_done = 0;

  upv_link_if link_i();
  upv_host #(.H_BLANK(HB), .V_BLANK(V_BLANK_MIN)) upv_host_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .supply_on_i(supply_on), .ten_bit_i(ten_bit), .px_data_i(px_data), .px_valid_i(px_valid),
    .px_ready_o(px_ready), .lock_seen_o(lock_seen), .link(link_i));
  upv_panel #(.NOSIG_TIMEOUT(NST)) upv_panel_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .depth_strap_i(strap),
    .auto_test_pattern_i(auto_test_pattern), .link(link_i), .px_o(px_out), .px_valid_o(px_vld),
    .px_col_o(col), .px_row_o(row), .signal_ok_o(sig_ok));
  upv_link_checker #(.H_BLANK(HB), .NOSIG_TIMEOUT(NST)) upv_link_checker_i (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i), .de(link_i.de), .hsync(link_i.hsync), .vsync(link_i.vsync), .data(link_i.data),
    .link_lock_flag(link_i.link_lock_flag), .hot_plug_flag(link_i.hot_plug_flag));

  always #10 ref_clk_i = ~ref_clk_i;

  function automatic logic [31:0] pk(input upv_rgb_s p, input logic t);
    return t ? {p.r[1:0], p.g[1:0], p.b[1:0], 2'h0, p.b[9:2], p.g[9:2], p.r[9:2]}
             : {8'h00, p.b[7:0], p.g[7:0], p.r[7:0]};
  endfunction : pk

  function automatic upv_rgb_s up(input upv_rgb_s p, input logic t);
    return t ? p : upv_rgb_s'{{p.r[7:0], 2'h0}, {p.g[7:0], 2'h0}, {p.b[7:0], 2'h0}};
  endfunction : up

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_w

  task automatic chk_px(input upv_rgb_s got, input upv_rgb_s exp);
    chk_w({2'h0, got}, {2'h0, exp});
  endtask : chk_px

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // Waits for k falls of data enable, bounded
  task automatic wait_fall(input int k);
    int   c;
    logic d;
    c = 0;
    d = link_i.de;
    for (int t = 0; t < 4000 * k && c < k; t++) begin
      @(negedge ref_clk_i);
      if (d && !link_i.de) c++;
      d = link_i.de;
    end
    if (c < k) begin
      err_count++;
      end_sim();
    end
  endtask : wait_fall

  // Source: all-ones and all-zeros pixels first, then random ones
  always @(posedge ref_clk_i) begin
    if (px_valid && px_ready) begin
      px_data <= (q.size() == 0) ? '0 : upv_rgb_s'(30'($urandom));
      q.push_back(px_data);
    end
  end

  // Wire words and panel pixels, the latter three edges after the pin
  always @(negedge ref_clk_i) begin
    if (pv[2] && sig_ok) begin
      chk_w({31'h0, px_vld}, 32'h1);
      chk_px(px_out, pipe[2]);
      chk_w({22'h0, col}, cp[2]);
      chk_w({20'h0, row}, rp[2]);
    end
    e = '0;
    if (link_i.de) begin
      e = q.pop_front();
      chk_w(link_i.data & (ten_bit ? 32'hFCFF_FFFF : 32'hFFFF_FFFF), pk(e, ten_bit));
    end
    for (int i = 3; i > 0; i--) begin
      pipe[i] = pipe[i-1];
      cp[i] = cp[i-1];
      rp[i] = rp[i-1];
    end
    pv = {pv[2:0], link_i.de};
    pipe[0] = up(e, strap);
    cp[0] = xcol;
    rp[0] = xrow;
    xcol = link_i.de ? xcol + 1 : 0;
    // Row advances after each line, back to 0 after a gap longer than any line blank
    gap = pv[0] ? 0 : gap + 1;
    if (gap > H_BLANK_MAX) begin
      xrow = 0;
    end else if (pv[1] && !pv[0]) begin
      xrow++;
    end
  end

  initial begin
    void'($urandom(32'h367F));
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    px_valid <= 1'b1;
    for (int n = 0; n < 40 && px_ready !== 1'b0; n++) @(negedge ref_clk_i);
    chk_w(q.size(), FIFO_DEPTH);
    chk_w({31'h0, link_i.de}, 32'h0);
    @(posedge ref_clk_i);
    supply_on <= 1'b1;
    wait_fall(3);
    chk_w({30'h0, sig_ok, lock_seen}, 32'h3);
    repeat (8) @(posedge ref_clk_i);
    ten_bit <= 1'b0;
    strap <= 1'b0;
    wait_fall(2);
    @(posedge ref_clk_i);
    supply_on <= 1'b0;
    px_valid <= 1'b0;
    repeat (NST + 60) @(negedge ref_clk_i);
    chk_w(link_i.data, 32'h0);
    chk_w({31'h0, sig_ok}, 32'h0);
    chk_w({31'h0, px_vld}, 32'h1);
    chk_px(px_out, '0);
    @(posedge ref_clk_i);
    auto_test_pattern <= 1'b1;
    seen = 1'b0;
    repeat (64) begin
      @(negedge ref_clk_i);
      seen = seen | (px_out !== '0);
    end
    chk_w({30'h0, px_vld, seen}, 32'h3);
    end_sim();
  end
endmodule : testbench
